// [hw/mra_consts.vh]
// constants of the region attribute access block
// Behaviour
// - build option picks mask or limit field
// - attribute register exists only with protection built
// - mask width equals base width, bit31 unused
// - mask is all ones shifted by log2(size/64)
// - unimplemented mask bits read zero, write zero
// - limit holds top address plus one, scaled
// - limit one bit wider, owns bit 31
// - cacheable flag: 0 uncached, 1 cached data
// - instruction regions read cacheable flag as zero
// - cache only with data cache, io forces uncached
// - address bit 31 bypass still honoured
// - instruction permission: none, supervisor, both execute
// - data permission codes 0,1,2,4,5,6 decoded
// - write with read flag and no write flag performs region read
// - read flag always reads back zero
// - write with write flag performs region write
// - write flag always reads back zero
// - base index and select pick the entry
// - base field 25 bits, address bits 6..30
// - up to 32 regions each, unused index zero
`ifndef MRA_CONSTS_VH
`define MRA_CONSTS_VH
`define MRA_WR_BIT      0
`define MRA_RD_BIT      1
`define MRA_ACCESS_PERMISSION_CODE_LO     2
`define MRA_ACCESS_PERMISSION_CODE_HI     4
`define MRA_C_BIT       5
`define MRA_FIELD_LO    6
`define MRA_BASE_W      25
`define MRA_BASE_DBIT   0
`define MRA_BASE_IDX_LO 1
`define MRA_ATTR_RESET  32'h00000000
`define MRA_BASE_RESET  32'h00000000
`define MRA_MASK_ALL    25'h1FFFFFF
`define MRA_MAX_REGIONS 32
`endif

// [hw/mra_region_table.v]
// flip-flop storage for one kind of protection region
`timescale 1ns/1ns
`default_nettype none
`include "mra_consts.vh"
module mra_region_table #(
	parameter NREG = 8,
	parameter IW   = 3,
	parameter EW   = 56
) (
	input  wire          mclk_in,  // core clock
	input  wire          nrst_in,  // async reset, low
	input  wire          we_in,    // store entry
	input  wire [IW-1:0] widx_in,  // write index
	input  wire [EW-1:0] wdata_in, // write data
	input  wire [IW-1:0]      ridx_in,   // read index
	output wire [EW-1:0]      rdata_out, // selected entry
	output wire [NREG*EW-1:0] flat_out   // all entries, for the match logic
);
	reg [EW-1:0] mem_q [0:NREG-1];
	integer i;
	// entries cleared at reset so a fresh read is defined
	always @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (i = 0; i < NREG; i = i + 1) begin
				mem_q[i] <= {EW{1'b0}};
			end
		end else if (we_in) begin
			mem_q[widx_in] <= wdata_in;
		end
	end
	assign rdata_out = mem_q[ridx_in];
	// every entry on one flat bus so the matcher needs no hierarchical peek
	genvar n;
	generate
		for (n = 0; n < NREG; n = n + 1) begin : g_flat
			assign flat_out[n*EW +: EW] = mem_q[n];
		end
	endgenerate
endmodule
`default_nettype wire

// [hw/mra_access_permission_code_check.v]
// permission decode for one access against one region attribute
`timescale 1ns/1ns
`default_nettype none
`include "mra_consts.vh"
module mra_access_permission_code_check (
	input  wire       is_data_in,  // data region when high
	input  wire [2:0] access_permission_code_in,     // access permission code
	input  wire       user_in,     // user mode access
	input  wire       write_in,    // data store
	output reg        allow_out    // access permitted
);
	// reserved codes deny; their behaviour is left undefined anyway
	always @* begin
		allow_out = 1'b0;
		if (!is_data_in) begin
			case (access_permission_code_in)
				3'h1: allow_out = !user_in;
				3'h2: allow_out = 1'b1;
				default: allow_out = 1'b0;
			endcase
		end else begin
			case (access_permission_code_in)
				3'h1: allow_out = !user_in && !write_in;
				3'h2: allow_out = !write_in;
				3'h4: allow_out = !user_in;
				3'h5: allow_out = !user_in || !write_in;
				3'h6: allow_out = 1'b1;
				default: allow_out = 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// [hw/mra_region_attr.v]
// region attribute access register with region table and checks
`timescale 1ns/1ns
`default_nettype none
`include "mra_consts.vh"
module mra_region_attr #(
	parameter USE_LIMIT  = 0,  // 0 mask field, 1 limit field
	parameter MPU_BUILT  = 1,  // protection unit present
	parameter DREGIONS   = 32, // data regions
	parameter IREGIONS   = 32, // instruction regions
	parameter IDX_W      = 5,  // index field width
	parameter MIN_SHIFT  = 0,  // log2(minimum region / 64)
	parameter HAS_DCACHE = 1   // data cache present
) (
	input  wire        mclk_in,      // core clock
	input  wire        nrst_in,      // async reset, low
	input  wire        ctl_wr_in,    // control write to attribute reg
	input  wire        base_wr_in,   // control write to base reg
	input  wire [31:0] ctl_wdata_in, // write data
	input  wire        chk_valid_in, // access check request
	input  wire        chk_data_in,  // data access when high
	input  wire        chk_user_in,  // user mode access
	input  wire        chk_write_in, // store access
	input  wire        chk_io_in,    // io load or store
	input  wire [31:0] chk_addr_in,  // access byte address
	output reg  [31:0] attr_rdata_out, // attribute register read value
	output reg  [31:0] base_rdata_out, // base register read value
	output reg         chk_hit_out,    // a region matched
	output reg         chk_allow_out,  // access permitted
	output reg         chk_cache_out   // access may be cached
);
	localparam FW = USE_LIMIT ? `MRA_BASE_W + 1 : `MRA_BASE_W;
	localparam EW = `MRA_BASE_W + FW + 4;
	localparam NR = (DREGIONS > IREGIONS) ? DREGIONS : IREGIONS;

	// implemented field bits: none below min region, all above
	localparam [`MRA_BASE_W-1:0] BMASK = `MRA_MASK_ALL << MIN_SHIFT;
	localparam [FW-1:0] FMASK = {{(FW-`MRA_BASE_W){1'b1}}, BMASK};

	reg  [FW-1:0]          field_q;
	reg                    c_q;
	reg  [2:0]             access_permission_code_q;
	reg  [`MRA_BASE_W-1:0] base_q;
	reg  [IDX_W-1:0]       idx_q;
	reg                    dsel_q;
	wire [EW-1:0]          d_entry;
	wire [EW-1:0]          i_entry;
	wire [EW-1:0]          sel_entry;
	wire [EW-1:0]          wr_entry;
	wire [DREGIONS*EW-1:0] d_all;
	wire [IREGIONS*EW-1:0] i_all;
	wire                   rd_req;
	wire                   wr_req;

	// request flags act only on the write; never stored
	assign rd_req = ctl_wr_in && ctl_wdata_in[`MRA_RD_BIT] && !ctl_wdata_in[`MRA_WR_BIT];
	assign wr_req = ctl_wr_in && ctl_wdata_in[`MRA_WR_BIT];

	// entry layout: {base, field, c, access_permission_code}
	assign wr_entry = {base_q, field_q, c_q & dsel_q, access_permission_code_q};

	// separate data and instruction tables
	mra_region_table #(.NREG(DREGIONS), .IW(IDX_W), .EW(EW)) u_dtab (
		.mclk_in  (mclk_in),
		.nrst_in  (nrst_in),
		.we_in    (wr_req && dsel_q),
		.widx_in  (idx_q),
		.wdata_in (wr_entry),
		.ridx_in  (idx_q),
		.rdata_out(d_entry),
		.flat_out (d_all)
	);
	mra_region_table #(.NREG(IREGIONS), .IW(IDX_W), .EW(EW)) u_itab (
		.mclk_in  (mclk_in),
		.nrst_in  (nrst_in),
		.we_in    (wr_req && !dsel_q),
		.widx_in  (idx_q),
		.wdata_in (wr_entry),
		.ridx_in  (idx_q),
		.rdata_out(i_entry),
		.flat_out (i_all)
	);
	assign sel_entry = dsel_q ? d_entry : i_entry;

	// attribute and base registers; region read reloads both
	always @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			field_q <= {FW{1'b0}};
			c_q     <= 1'b0;
			access_permission_code_q  <= 3'h0;
			base_q  <= {`MRA_BASE_W{1'b0}};
			idx_q   <= {IDX_W{1'b0}};
			dsel_q  <= 1'b0;
		end else if (MPU_BUILT != 0) begin
			if (rd_req) begin
				base_q  <= sel_entry[EW-1 -: `MRA_BASE_W];
				field_q <= sel_entry[FW+3:4];
				c_q     <= sel_entry[3];
				access_permission_code_q  <= sel_entry[2:0];
			end else if (ctl_wr_in && !wr_req) begin
				field_q <= ctl_wdata_in[`MRA_FIELD_LO +: FW] & FMASK;
				c_q     <= ctl_wdata_in[`MRA_C_BIT] & dsel_q;
				access_permission_code_q  <= ctl_wdata_in[`MRA_ACCESS_PERMISSION_CODE_HI:`MRA_ACCESS_PERMISSION_CODE_LO];
			end
			if (base_wr_in) begin
				base_q <= ctl_wdata_in[`MRA_FIELD_LO +: `MRA_BASE_W] & BMASK;
				idx_q  <= ctl_wdata_in[`MRA_BASE_IDX_LO +: IDX_W];
				dsel_q <= ctl_wdata_in[`MRA_BASE_DBIT];
			end
		end
	end

	// register read views; unused bits and request flags read zero
	always @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			attr_rdata_out <= `MRA_ATTR_RESET;
			base_rdata_out <= `MRA_BASE_RESET;
		end else if (MPU_BUILT != 0) begin
			attr_rdata_out <= {{(26-FW){1'b0}}, field_q, c_q & dsel_q, access_permission_code_q, 2'b00};
			base_rdata_out <= {1'b0, base_q, {(6-IDX_W-1){1'b0}}, idx_q, dsel_q};
		end
	end

	// region match over the table of the access kind, lowest index wins
	wire [NR-1:0]  hit_vec;
	wire [NR*3-1:0] access_permission_code_vec;
	wire [NR-1:0]  c_vec;
	genvar g;
	generate
		for (g = 0; g < NR; g = g + 1) begin : g_match
			wire [EW-1:0]          e;
			wire [`MRA_BASE_W-1:0] ab;
			wire [`MRA_BASE_W-1:0] eb;
			wire [FW-1:0]          ef;
			wire                   en;
			assign en = chk_data_in ? (g < DREGIONS) : (g < IREGIONS);
			assign e  = chk_data_in ? d_all[(g % DREGIONS)*EW +: EW] : i_all[(g % IREGIONS)*EW +: EW];
			assign ab = chk_addr_in[30:6];
			assign eb = e[EW-1 -: `MRA_BASE_W];
			assign ef = e[FW+3:4];
			if (USE_LIMIT != 0) begin : g_lim
				// limit is exclusive top, same scaling as base
				assign hit_vec[g] = en && ({1'b0, ab} >= {1'b0, eb}) && ({1'b0, ab} < ef);
			end else begin : g_msk
				// mask keeps the bits that name the region
				assign hit_vec[g] = en && ((ab & ef[`MRA_BASE_W-1:0]) == (eb & ef[`MRA_BASE_W-1:0]));
			end
			assign access_permission_code_vec[g*3 +: 3] = e[2:0];
			assign c_vec[g] = e[3];
		end
	endgenerate

	reg       any_hit;
	reg [2:0] hit_access_permission_code;
	reg       hit_c;
	integer k;
	// priority pick of the first matching entry
	always @* begin
		any_hit  = 1'b0;
		hit_access_permission_code = 3'h0;
		hit_c    = 1'b0;
		for (k = NR - 1; k >= 0; k = k - 1) begin
			if (hit_vec[k]) begin
				any_hit  = 1'b1;
				hit_access_permission_code = access_permission_code_vec[k*3 +: 3];
				hit_c    = c_vec[k];
			end
		end
	end

	wire access_permission_code_ok;
	mra_access_permission_code_check u_access_permission_code (
		.is_data_in(chk_data_in),
		.access_permission_code_in   (hit_access_permission_code),
		.user_in   (chk_user_in),
		.write_in  (chk_write_in),
		.allow_out (access_permission_code_ok)
	);

	// registered check result; bit 31 and io bypass the cache
	always @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			chk_hit_out   <= 1'b0;
			chk_allow_out <= 1'b0;
			chk_cache_out <= 1'b0;
		end else begin
			chk_hit_out   <= chk_valid_in && any_hit;
			chk_allow_out <= chk_valid_in && any_hit && access_permission_code_ok;
			chk_cache_out <= chk_valid_in && any_hit && chk_data_in && hit_c && (HAS_DCACHE != 0)
			                 && !chk_io_in && !chk_addr_in[31];
		end
	end
endmodule
`default_nettype wire

// [verification/mra_attr_asserts.sv]
// port assertions for the region attribute block
`timescale 1ns/1ns
`default_nettype none
module mra_attr_chk #(parameter USE_LIMIT = 0) (
	input wire logic        mclk_in,        // clock
	input wire logic        nrst_in,        // reset, low
	input wire logic        ctl_wr_in,      // attr write
	input wire logic        base_wr_in,     // base write
	input wire logic [31:0] ctl_wdata_in,   // write data
	input wire logic        chk_valid_in,   // access
	input wire logic        chk_data_in,    // data access
	input wire logic        chk_io_in,      // io access
	input wire logic [31:0] chk_addr_in,    // address
	input wire logic [31:0] attr_rdata_out, // attr view
	input wire logic [31:0] base_rdata_out, // base view
	input wire logic        chk_cache_out   // cacheable
);
	logic sel_q; // select of the last base write
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);
	// region reads keep the select, so only base writes move it
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			sel_q <= 1'h0;
		else if (base_wr_in)
			sel_q <= ctl_wdata_in[0];
	end
	chk_flags_zero: assert property (attr_rdata_out[1:0] == 2'h0)
		else $error("request flag reads set");
	chk_mask_top: assert property (USE_LIMIT != 0 || !attr_rdata_out[31])
		else $error("mask bit 31 set");
	chk_base_top: assert property (!base_rdata_out[31])
		else $error("base bit 31 set");
	chk_field_wr: assert property (ctl_wr_in && ctl_wdata_in[1:0] == 2'h0 && USE_LIMIT == 0 |-> ##2
		attr_rdata_out[30:6] == $past(ctl_wdata_in[30:6], 2) && attr_rdata_out[4:2] == $past(ctl_wdata_in[4:2], 2))
		else $error("fields not taken");
	chk_instr_uncached: assert property (ctl_wr_in && !sel_q && ctl_wdata_in[1:0] == 2'h0 |-> ##2 !attr_rdata_out[5])
		else $error("instruction region cacheable");
	chk_base_wr: assert property (base_wr_in |-> ##2 base_rdata_out == {1'h0, $past(ctl_wdata_in[30:0], 2)})
		else $error("base not taken");
	chk_io_unc: assert property (chk_valid_in && chk_io_in |=> !chk_cache_out)
		else $error("io access cacheable");
	chk_bypass_unc: assert property (chk_valid_in && chk_data_in && chk_addr_in[31] |=> !chk_cache_out)
		else $error("bypass access cacheable");
endmodule
bind mra_region_attr mra_attr_chk #(.USE_LIMIT(USE_LIMIT)) mra_attr_chk_inst (.mclk_in, .nrst_in, .ctl_wr_in,
	.base_wr_in, .ctl_wdata_in, .chk_valid_in, .chk_data_in, .chk_io_in, .chk_addr_in, .attr_rdata_out,
	.base_rdata_out, .chk_cache_out);
`default_nettype wire

// [verification/mra_core_model.sv]
// core model: control writes and reads, checked accesses
`timescale 1ns/1ns
`default_nettype none
module mra_core_model (
	input  wire logic        mclk_in,     // clock
	input  wire logic [31:0] attr_in,     // attr view
	input  wire logic [31:0] base_in,     // base view
	input  wire logic [2:0]  res_in,      // hit allow cache
	output var logic         attr_wr_out, // attr write
	output var logic         base_wr_out, // base write
	output var logic [31:0]  wdata_out,   // write data
	output var logic         valid_out,   // access
	output var logic [3:0]   kind_out,    // data user write io
	output var logic [31:0]  addr_out     // address
);
	// idle before reset ends
	initial {attr_wr_out, base_wr_out, valid_out, kind_out, wdata_out, addr_out} = 71'h0;
	// strobe spans one edge; data flips once released so stale values never match
	task automatic wrctl(input logic attr, input logic [31:0] d);
		@(negedge mclk_in);
		attr_wr_out = attr;
		base_wr_out = !attr;
		wdata_out = attr ? {d[31:2], d[1] & !d[0], d[0]} : d;
		@(negedge mclk_in);
		attr_wr_out = 1'h0;
		base_wr_out = 1'h0;
		wdata_out = ~d;
		repeat (2) @(negedge mclk_in); // views settle two edges on
	endtask
	task automatic rdctl(input logic attr, output logic [31:0] q);
		q = attr ? attr_in : base_in;
	endtask
	// results are registered at the request edge
	task automatic access(input logic [31:0] a, input logic [3:0] k, output logic [2:0] r);
		@(negedge mclk_in);
		valid_out = 1'h1;
		kind_out = k;
		addr_out = a;
		@(negedge mclk_in);
		r = res_in;
		valid_out = 1'h0;
		addr_out = ~a;
	endtask
endmodule
`default_nettype wire

// [verification/mra_region_attr_tb_top.sv]
// testbench for the region attribute block
`timescale 1ns/1ns
`default_nettype none
module mra_region_attr_tb_top;
	logic             mclk_in = 1'h0;
	logic             nrst_in = 1'h0;
	wire logic        attr_wr, base_wr, valid;
	wire logic [3:0]  kind;
	wire logic [31:0] wdata, addr, attr_q, base_q;
	wire logic [2:0]  res;
	wire logic [2:0]  lres;
	wire logic [31:0] lattr;
	int               n_fail = 0;
	int               checks_done = 0;
	int               cycles = 0;
	logic [31:0]      q;
	logic [2:0]       r;
	logic [2:0]       codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6}; // listed codes only
	logic [31:0]      probe [4] = '{32'h43FC, 32'h4400, 32'h803C, 32'h8040};
	always #20 mclk_in = ~mclk_in;
	// mask build never sees bit 31 set; its port tie forces it zero there
	mra_region_attr mra_region_attr_inst (.mclk_in, .nrst_in, .ctl_wr_in(attr_wr), .base_wr_in(base_wr),
		.ctl_wdata_in({1'h0, wdata[30:0]}), .chk_valid_in(valid), .chk_data_in(kind[3]), .chk_user_in(kind[2]),
		.chk_write_in(kind[1]), .chk_io_in(kind[0]), .chk_addr_in(addr), .attr_rdata_out(attr_q),
		.base_rdata_out(base_q), .chk_hit_out(res[2]), .chk_allow_out(res[1]), .chk_cache_out(res[0]));
	mra_core_model core (.mclk_in, .attr_in(attr_q), .base_in(base_q), .res_in(res), .attr_wr_out(attr_wr),
		.base_wr_out(base_wr), .wdata_out(wdata), .valid_out(valid), .kind_out(kind), .addr_out(addr));
	// limit build on the same stimulus; bit 31 reaches its field
	mra_region_attr #(.USE_LIMIT(1)) mra_region_attr_lim_inst (.mclk_in, .nrst_in, .ctl_wr_in(attr_wr),
		.base_wr_in(base_wr), .ctl_wdata_in(wdata), .chk_valid_in(valid), .chk_data_in(kind[3]),
		.chk_user_in(kind[2]), .chk_write_in(kind[1]), .chk_io_in(kind[0]), .chk_addr_in(addr),
		.attr_rdata_out(lattr), .base_rdata_out(), .chk_hit_out(lres[2]), .chk_allow_out(lres[1]),
		.chk_cache_out(lres[0]));
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t access %b expected %b", $time, got, exp);
		end
	endtask
	// expected permission outcome
	function automatic logic allow(input logic d, input logic [2:0] p, input logic u, input logic w);
		if (!d)
			return p == 3'h2 || (p == 3'h1 && !u);
		return p == 3'h6 || (p == 3'h5 && !(u && w)) || (p == 3'h4 && !u) || (!w && (p == 3'h2 || (p == 3'h1 && !u)));
	endfunction
	// base first, then fields, then the store request; bit 31 kept zero
	task automatic region(input logic d, input logic [4:0] i, input logic [24:0] b, input logic [24:0] m,
		input logic [3:0] pc);
		core.wrctl(1'h0, {1'h0, b, i, d});
		core.wrctl(1'h1, {1'h0, m, pc, 2'h0});
		core.wrctl(1'h1, {1'h0, m, pc, 2'h1});
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// a hang ends the run as a mismatch
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(negedge mclk_in);
		nrst_in = 1'h1;
		cmp32(attr_q, 32'h0);
		cmp32(base_q, 32'h0);
		// instruction codes then data codes, region 0 at 0x4000, 1 KB; instruction c written 0
		for (int d = 0; d < 2; d++)
			for (int j = 0; j < 6; j++)
				if (d || codes[j] < 3'h4) begin
					region(d[0], 5'h0, 25'h100, 25'h1FFFFF0, {d[0], codes[j]});
					for (int k = 0; k < 4; k++) begin
						core.access(32'h4010, {d[0], k[1], k[0] & d[0], 1'h0}, r);
						cmp3(r & 3'h6, {1'h1, allow(d[0], codes[j], k[1], k[0] & d[0]), 1'h0});
						cmp3(lres & 3'h6, {1'h1, allow(d[0], codes[j], k[1], k[0] & d[0]), 1'h0});
					end
				end
		// second region of 64 bytes, then read region 0 back over a junk base
		region(1'h1, 5'h1, 25'h200, 25'h1FFFFFF, 4'h1);
		core.wrctl(1'h0, 32'h7FFFFFC1);
		core.wrctl(1'h1, 32'h2);
		core.rdctl(1'h1, q);
		cmp32(q, {1'h0, 25'h1FFFFF0, 4'hE, 2'h0});
		cmp32(lattr, {1'h0, 25'h1FFFFF0, 4'hE, 2'h0});
		core.rdctl(1'h0, q);
		cmp32(q, 32'h4001);
		// region edges: past the end falls to a zero entry that denies
		for (int j = 0; j < 4; j++) begin
			core.access(probe[j], 4'h8, r);
			cmp3(r & 3'h6, {1'h1, !j[0], 1'h0});
		end
		core.access(32'h4010, 4'h8, r);
		cmp3(r, 3'h7);
		core.access(32'h4010, 4'h9, r);
		cmp3(r, 3'h6);
		core.access(32'h80004010, 4'h8, r);
		cmp3(r, 3'h6);
		core.access(32'h8000, 4'h8, r);
		cmp3(r, 3'h6);
		// limit build: top exclusive, base inclusive, lowest index first
		core.access(32'h7FFFFBFC, 4'hA, r);
		cmp3(lres, 3'h7);
		core.access(32'h7FFFFC00, 4'hA, r);
		cmp3(lres, 3'h4);
		core.access(32'h3FFC, 4'h8, r);
		cmp3(lres, 3'h0);
		// bit 31 belongs to the limit only; the mask build reads it zero
		core.wrctl(1'h1, 32'h80000018);
		cmp32(lattr, 32'h80000018);
		core.rdctl(1'h1, q);
		cmp32(q, 32'h18);
		test_done();
	end
endmodule
`default_nettype wire
